// File: rtl/bdsc_ctrl.sv
`timescale 1ns/10ps
// Operation
// RL1 - Registers reached only by serial debug commands
// RL2 - Halt permit frozen while halted
// RL3 - Four status bits are read-only
// RL4 - Clock select bit 3, RW, resets 0
// RL5 - Halt permit bit 7 cleared by reset
// RL6 - Bit 6 shows CPU halted in background
// RL7 - Breakpoint enable 0 disables breakpoint logic
// RL8 - Force select: match halts at boundary
// RL9 - Tag select: match tags fetched opcode
// RL10 - Bit 2 shows wait/stop or woken
// RL11 - Background command exits wait/stop
// RL12 - Host checks active bit after background
// RL13 - Bit 1 set on wait/stop access failure
// RL14 - Host recovers from wait/stop failure
// RL15 - Bit 0 unused, no slow memory
// RL16 - Match register via breakpoint commands only
// RL17 - Breakpoint without permit gives software interrupt
// RL18 - Unused data-valid bit reads zero
module bdsc_ctrl (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    input  wire bdsc_pkg::bdsc_req_t req_i,
    output logic                   rsp_valid_o,
    output logic [15:0]            rsp_data_o,
    input  wire logic [15:0]       cpu_addr_i,
    input  wire logic              cpu_addr_valid_i,
    input  wire logic              cpu_halted_i,
    input  wire logic              cpu_wait_stop_i,
    input  wire logic              mem_access_fail_i,
    output logic                   force_halt_o,
    output logic                   tag_opcode_o,
    output logic                   software_interrupt_o,
    output logic                   background_req_o,
    output logic                   comm_clock_select_o
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic        halt_permit_q,        halt_permit_d;
    logic        breakpoint_enable_q,  breakpoint_enable_d;
    logic        force_tag_select_q,   force_tag_select_d;
    logic        comm_clock_select_q,  comm_clock_select_d;
    logic        wait_stop_flag_q,     wait_stop_flag_d;
    logic        ws_fail_flag_q,       ws_fail_flag_d;
    logic [15:0] bkpt_q,               bkpt_d;
    logic        rsp_valid_q,          rsp_valid_d;
    logic [15:0] rsp_data_q,           rsp_data_d;
    bdsc_pkg::bdsc_brk_t brk_q,        brk_d;
    logic        bgnd_q,               bgnd_d;
    logic [7:0]  status;
    logic        match;

    // Status image; bit 0 hard zero [RL15] [RL18]
    always_comb begin
        status = 8'h00;
        status[bdsc_pkg::HALT_PERMIT_BIT] = halt_permit_q;
        status[bdsc_pkg::HALT_ACTIVE_BIT] = cpu_halted_i;          // [RL6]
        status[bdsc_pkg::BKPT_ENABLE_BIT] = breakpoint_enable_q;
        status[bdsc_pkg::FORCE_TAG_BIT]   = force_tag_select_q;
        status[bdsc_pkg::COMM_CLK_BIT]    = comm_clock_select_q;
        status[bdsc_pkg::WAIT_STOP_BIT]   = wait_stop_flag_q;
        status[bdsc_pkg::WS_FAIL_BIT]     = ws_fail_flag_q;
    end

    assign match = breakpoint_enable_q && cpu_addr_valid_i  // [RL7]
                   && (cpu_addr_i == bkpt_q);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        halt_permit_d       = halt_permit_q;
        breakpoint_enable_d = breakpoint_enable_q;
        force_tag_select_d  = force_tag_select_q;
        comm_clock_select_d = comm_clock_select_q;
        wait_stop_flag_d    = wait_stop_flag_q;
        ws_fail_flag_d      = ws_fail_flag_q;
        bkpt_d              = bkpt_q;
        rsp_valid_d         = 1'b0;
        rsp_data_d          = rsp_data_q;
        brk_d               = '0;
        bgnd_d              = 1'b0;
        // Only the serial command port reaches these registers [RL1]
        case (req_i.cmd)
            bdsc_pkg::CMD_READ_STATUS: begin
                rsp_valid_d = 1'b1;
                rsp_data_d  = {8'h00, status};
            end
            bdsc_pkg::CMD_WRITE_CONTROL: begin
                if (!cpu_halted_i) begin                           // [RL2]
                    halt_permit_d = req_i.data[bdsc_pkg::HALT_PERMIT_BIT];
                end
                breakpoint_enable_d = req_i.data[bdsc_pkg::BKPT_ENABLE_BIT];
                force_tag_select_d  = req_i.data[bdsc_pkg::FORCE_TAG_BIT];
                // Clock select writable at any time [RL4]
                comm_clock_select_d = req_i.data[bdsc_pkg::COMM_CLK_BIT];
                // Status bits untouched by writes [RL3]
            end
            bdsc_pkg::CMD_READ_BKPT: begin
                rsp_valid_d = 1'b1;
                rsp_data_d  = bkpt_q;                              // [RL16]
            end
            bdsc_pkg::CMD_WRITE_BKPT: begin
                bkpt_d = req_i.data;                               // [RL16]
            end
            bdsc_pkg::CMD_BACKGROUND: begin
                // With halt permit set, works even in wait/stop; forces the CPU out [RL11]
                if (halt_permit_q) begin
                    bgnd_d = 1'b1;
                end
            end
            default: begin
            end
        endcase

        // Wait/stop flag: live in wait/stop, held if woken to background
        if (cpu_wait_stop_i) begin
            wait_stop_flag_d = 1'b1;                               // [RL10]
        end else if (!cpu_halted_i) begin
            wait_stop_flag_d = 1'b0;                               // [RL10]
        end

        // Set wins; cleared once the CPU resumes user code
        if (mem_access_fail_i && cpu_wait_stop_i) begin
            ws_fail_flag_d = 1'b1;                                 // [RL13]
        end else if (!cpu_halted_i && !cpu_wait_stop_i) begin
            ws_fail_flag_d = 1'b0;
        end

        if (match && !cpu_halted_i) begin
            if (!halt_permit_q) begin
                brk_d.software_interrupt = 1'b1;                                  // [RL17]
            end else if (force_tag_select_q) begin
                brk_d.force_halt = 1'b1;                           // [RL8]
            end else begin
                brk_d.tag_opcode = 1'b1;                           // [RL9]
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            halt_permit_q       <=
                bdsc_pkg::CTRL_RESET[bdsc_pkg::HALT_PERMIT_BIT];   // [RL5]
            breakpoint_enable_q <=
                bdsc_pkg::CTRL_RESET[bdsc_pkg::BKPT_ENABLE_BIT];
            force_tag_select_q  <=
                bdsc_pkg::CTRL_RESET[bdsc_pkg::FORCE_TAG_BIT];
            comm_clock_select_q <=
                bdsc_pkg::CTRL_RESET[bdsc_pkg::COMM_CLK_BIT];      // [RL4]
            wait_stop_flag_q    <= 1'b0;
            ws_fail_flag_q      <= 1'b0;
            bkpt_q              <= bdsc_pkg::BKPT_RESET;
            rsp_valid_q         <= 1'b0;
            rsp_data_q          <= 16'h0000;
            brk_q               <= '0;
            bgnd_q              <= 1'b0;
        end else if (ce_i) begin
            halt_permit_q       <= halt_permit_d;
            breakpoint_enable_q <= breakpoint_enable_d;
            force_tag_select_q  <= force_tag_select_d;
            comm_clock_select_q <= comm_clock_select_d;
            wait_stop_flag_q    <= wait_stop_flag_d;
            ws_fail_flag_q      <= ws_fail_flag_d;
            bkpt_q              <= bkpt_d;
            rsp_valid_q         <= rsp_valid_d;
            rsp_data_q          <= rsp_data_d;
            brk_q               <= brk_d;
            bgnd_q              <= bgnd_d;
        end
    end

    assign rsp_valid_o          = rsp_valid_q;
    assign rsp_data_o           = rsp_data_q;
    assign force_halt_o         = brk_q.force_halt;
    assign tag_opcode_o         = brk_q.tag_opcode;
    assign software_interrupt_o = brk_q.software_interrupt;
    assign background_req_o     = bgnd_q;
    assign comm_clock_select_o  = comm_clock_select_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_write_while_halted;
        ce_i && req_i.cmd == bdsc_pkg::CMD_WRITE_CONTROL && cpu_halted_i;
    endsequence

    property p_permit_frozen;
        @(posedge clk_i) disable iff (rst_i)
        s_write_while_halted |=> $stable(halt_permit_q);
    endproperty
    a_permit_frozen: assert property (p_permit_frozen) // [RL2]
        else $error("halt permit changed while halted");

    property p_clk_write;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && req_i.cmd == bdsc_pkg::CMD_WRITE_CONTROL
        |=> comm_clock_select_o
            == $past(req_i.data[bdsc_pkg::COMM_CLK_BIT]);
    endproperty
    a_clk_write: assert property (p_clk_write) // [RL4]
        else $error("clock select not written");

    property p_dvf_zero;
        @(posedge clk_i) disable iff (rst_i)
        rsp_valid_o && $past(ce_i)
        && $past(req_i.cmd) == bdsc_pkg::CMD_READ_STATUS
        |-> rsp_data_o[bdsc_pkg::DV_FAIL_BIT] == 1'b0;
    endproperty
    a_dvf_zero: assert property (p_dvf_zero) // [RL18]
        else $error("data valid fail bit read as one");

    property p_active_read;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && req_i.cmd == bdsc_pkg::CMD_READ_STATUS
        |=> rsp_valid_o
            && rsp_data_o[bdsc_pkg::HALT_ACTIVE_BIT] == $past(cpu_halted_i);
    endproperty
    a_active_read: assert property (p_active_read) // [RL6]
        else $error("active bit mismatch on status read");

    property p_no_brk_disabled;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !breakpoint_enable_q
        |=> !force_halt_o && !tag_opcode_o && !software_interrupt_o;
    endproperty
    a_no_brk_disabled: assert property (p_no_brk_disabled) // [RL7]
        else $error("breakpoint while disabled");

    property p_force;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && match && !cpu_halted_i && halt_permit_q && force_tag_select_q
        |=> force_halt_o && !tag_opcode_o;
    endproperty
    a_force: assert property (p_force) // [RL8]
        else $error("force breakpoint missing");

    property p_tag;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && match && !cpu_halted_i && halt_permit_q && !force_tag_select_q
        |=> tag_opcode_o && !force_halt_o;
    endproperty
    a_tag: assert property (p_tag) // [RL9]
        else $error("tag breakpoint missing");

    property p_swi;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && match && !cpu_halted_i && !halt_permit_q
        |=> software_interrupt_o && !force_halt_o && !tag_opcode_o;
    endproperty
    a_swi: assert property (p_swi) // [RL17]
        else $error("software interrupt missing");

    property p_ws_set;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && cpu_wait_stop_i |=> wait_stop_flag_q;
    endproperty
    a_ws_set: assert property (p_ws_set) // [RL10]
        else $error("wait/stop flag not set");

    property p_wsf_set;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && mem_access_fail_i && cpu_wait_stop_i |=> ws_fail_flag_q;
    endproperty
    a_wsf_set: assert property (p_wsf_set) // [RL13]
        else $error("wait/stop fail flag not set");

    property p_bgnd;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && req_i.cmd == bdsc_pkg::CMD_BACKGROUND && halt_permit_q
        |=> background_req_o;
    endproperty
    a_bgnd: assert property (p_bgnd) // [RL11]
        else $error("background request missing");

endmodule : bdsc_ctrl

// File: rtl/bdsc_pkg.sv
package bdsc_pkg;

    // ------------------------------------------------------------
    // Status/control field positions
    // ------------------------------------------------------------
    localparam int unsigned HALT_PERMIT_BIT  = 7;
    localparam int unsigned HALT_ACTIVE_BIT  = 6;
    localparam int unsigned BKPT_ENABLE_BIT  = 5;
    localparam int unsigned FORCE_TAG_BIT    = 4;
    localparam int unsigned COMM_CLK_BIT     = 3;
    localparam int unsigned WAIT_STOP_BIT    = 2;
    localparam int unsigned WS_FAIL_BIT      = 1;
    localparam int unsigned DV_FAIL_BIT      = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_RESET = 8'h00;
    localparam logic [15:0] BKPT_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Serial debug commands reaching the registers
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_READ_STATUS,
        CMD_WRITE_CONTROL,
        CMD_READ_BKPT,
        CMD_WRITE_BKPT,
        CMD_BACKGROUND
    } bdsc_cmd_t;

    typedef struct packed {
        bdsc_cmd_t   cmd;
        logic [15:0] data;
    } bdsc_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } bdsc_rsp_t;

    // Break action requested of the CPU
    typedef struct packed {
        logic force_halt;
        logic tag_opcode;
        logic software_interrupt;
    } bdsc_brk_t;

endpackage : bdsc_pkg

// File: tb/bdsc_host.sv
`timescale 1ns/10ps
module bdsc_host (
    input  wire logic           clk_i,
    input  wire logic           rsp_valid_i,
    input  wire logic [15:0]    rsp_data_i,
    output bdsc_pkg::bdsc_req_t req_o
);
    initial begin
        req_o.cmd  = bdsc_pkg::CMD_NONE;
        req_o.data = 16'h0000;
    end
    // One command per cycle; data is scrambled once released
    task automatic send(input bdsc_pkg::bdsc_cmd_t c, input logic [15:0] d);
        @(posedge clk_i);
        #1;
        req_o.cmd = c;
        req_o.data = d;
        @(posedge clk_i);
        #1;
        req_o.cmd = bdsc_pkg::CMD_NONE;
        req_o.data = ~d;
    endtask : send
    // Bounded wait for the answer pulse
    task automatic read(input bdsc_pkg::bdsc_cmd_t c, output logic [15:0] d);
        int n;
        n = 0;
        send(c, 16'h0000);
        while (rsp_valid_i !== 1'b1 && n < 4) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        d = (rsp_valid_i === 1'b1) ? rsp_data_i : 16'hXXXX;
    endtask : read
    // Background, then read status so the caller can check the active bit
    task automatic background(output logic [15:0] st);
        send(bdsc_pkg::CMD_BACKGROUND, 16'h0000);
        repeat (2) @(posedge clk_i);
        read(bdsc_pkg::CMD_READ_STATUS, st);
    endtask : background
endmodule : bdsc_host

// File: tb/background_debug_status_control_bench.sv
`timescale 1ns/10ps
module background_debug_status_control_bench;
    logic                clk_i, rst_i, ce_i, rsp_valid_o, clr;
    bdsc_pkg::bdsc_req_t req;
    logic [15:0]         rsp_data_o, cpu_addr_i, rd;
    logic                cpu_addr_valid_i, cpu_halted_i, cpu_wait_stop_i;
    logic                mem_access_fail_i, force_halt_o, tag_opcode_o;
    logic                software_interrupt_o, background_req_o, comm_clk;
    logic [3:0]          seen;
    int                  err_count, checks;
    logic [7:0]          cfg [5] = '{8'hB0, 8'hA0, 8'h90, 8'h30, 8'hB0};
    logic [15:0]         adr [5] = '{16'hA55A, 16'hA55A, 16'hA55A,
                                     16'hA55A, 16'hA55B};
    logic [3:0]          exp [5] = '{4'h1, 4'h2, 4'h0, 4'h4, 4'h0};

    bdsc_host bdsc_host_i (.clk_i(clk_i), .rsp_valid_i(rsp_valid_o),
                           .rsp_data_i(rsp_data_o), .req_o(req));
    bdsc_ctrl bdsc_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .req_i(req), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
        .cpu_addr_i(cpu_addr_i), .cpu_addr_valid_i(cpu_addr_valid_i),
        .cpu_halted_i(cpu_halted_i), .cpu_wait_stop_i(cpu_wait_stop_i),
        .mem_access_fail_i(mem_access_fail_i), .force_halt_o(force_halt_o),
        .tag_opcode_o(tag_opcode_o),
        .software_interrupt_o(software_interrupt_o),
        .background_req_o(background_req_o),
        .comm_clock_select_o(comm_clk));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Sticky capture so one-cycle pulses cannot slip past
    always @(posedge clk_i)
        seen <= clr ? 4'h0 : seen | {background_req_o,
                software_interrupt_o, tag_opcode_o, force_halt_o};

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test
    task automatic status(input logic [15:0] e);
        bdsc_host_i.read(bdsc_pkg::CMD_READ_STATUS, rd);
        chk(rd, e);
    endtask : status
    task automatic ctrl(input logic [7:0] v);
        bdsc_host_i.send(bdsc_pkg::CMD_WRITE_CONTROL, {8'h00, v});
    endtask : ctrl
    task automatic brk(input logic [15:0] a);
        @(posedge clk_i);
        #1;
        clr = 1'b1;
        cpu_addr_i = a;
        cpu_addr_valid_i = 1'b1;
        @(posedge clk_i);
        #1;
        clr = 1'b0;
        cpu_addr_valid_i = 1'b0;
        cpu_addr_i = ~a;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : brk

    // ------------------------------------------------------------
    // Watchdog, well above the roughly 110 cycles the tests need
    // ------------------------------------------------------------
    initial begin
        #20000;
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {rst_i, ce_i, clr} = 3'b111;
        {cpu_addr_valid_i, cpu_halted_i, cpu_wait_stop_i} = 3'b000;
        mem_access_fail_i = 1'b0;
        cpu_addr_i = 16'h0000;
        err_count = 0;
        checks = 0;
        repeat (8) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        status(16'h0000);
        bdsc_host_i.read(bdsc_pkg::CMD_READ_BKPT, rd);
        chk(rd, 16'h0000);
        chk({15'h0, comm_clk}, 16'h0000);
        $display("test reset done");
        ctrl(8'hFF);
        status(16'h00B8);
        chk({15'h0, comm_clk}, 16'h0001);
        ctrl(8'h00);
        chk({15'h0, comm_clk}, 16'h0000);
        bdsc_host_i.send(bdsc_pkg::CMD_WRITE_BKPT, 16'hA55A);
        bdsc_host_i.read(bdsc_pkg::CMD_READ_BKPT, rd);
        chk(rd, 16'hA55A);
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            ctrl(cfg[i]);
            brk(adr[i]);
            chk({12'h0, seen}, {12'h0, exp[i]});
        end
        $display("test breakpoints done");
        ctrl(8'h80);
        cpu_halted_i = 1'b1;
        status(16'h00C0);
        ctrl(8'h30);
        status(16'h00F0);
        brk(16'hA55A);
        chk({12'h0, seen}, 16'h0000);
        cpu_halted_i = 1'b0;
        status(16'h00B0);
        $display("test halted done");
        cpu_wait_stop_i = 1'b1;
        status(16'h00B4);
        @(posedge clk_i);
        #1;
        mem_access_fail_i = 1'b1;
        @(posedge clk_i);
        #1;
        mem_access_fail_i = 1'b0;
        status(16'h00B6);
        clr = 1'b1;
        @(posedge clk_i);
        #1;
        clr = 1'b0;
        bdsc_host_i.send(bdsc_pkg::CMD_BACKGROUND, 16'h0000);
        repeat (3) @(posedge clk_i);
        #1;
        chk({12'h0, seen}, 16'h0008);
        {cpu_wait_stop_i, cpu_halted_i} = 2'b01;
        status(16'h00F6);
        cpu_halted_i = 1'b0;
        status(16'h00B0);
        $display("test wait stop done");
        ctrl(8'h00);
        clr = 1'b1;
        @(posedge clk_i);
        #1;
        clr = 1'b0;
        bdsc_host_i.background(rd);
        chk({12'h0, seen}, 16'h0000);
        chk(rd, 16'h0000);
        $display("test permit done");
        ctrl(8'hFF);
        // Commands offered with the enable low must be lost
        ce_i = 1'b0;
        ctrl(8'h00);
        bdsc_host_i.send(bdsc_pkg::CMD_WRITE_BKPT, 16'h1234);
        ce_i = 1'b1;
        status(16'h00B8);
        chk({15'h0, comm_clk}, 16'h0001);
        bdsc_host_i.read(bdsc_pkg::CMD_READ_BKPT, rd);
        chk(rd, 16'hA55A);
        // Mid-run reset with the permit set
        rst_i = 1'b1;
        @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        status(16'h0000);
        bdsc_host_i.read(bdsc_pkg::CMD_READ_BKPT, rd);
        chk(rd, 16'h0000);
        chk({15'h0, comm_clk}, 16'h0000);
        $display("test freeze and reset done");
        finish_test();
    end
endmodule : background_debug_status_control_bench
